// ---- src/dts_consts.svh ----
`ifndef DTS_CONSTS_SVH
`define DTS_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define DTS_CTRL_IDX       8'h01
`define DTS_SYNC_IDX       8'h03
`define DTS_CTRL_ADDR      (8'(`DTS_CTRL_IDX * 4))
`define DTS_SYNC_ADDR      (8'(`DTS_SYNC_IDX * 4))
`define DTS_STAT_ADDR      8'h10
`define DTS_MASK_ADDR      8'h14

// Field positions of the shared control register.
`define DTS_MODE_BIT       7
`define DTS_ROUTE_BIT      6
`define DTS_SEL_BIT        6
`define DTS_LOGIC_HI       5
`define DTS_LOGIC_LO       4
`define DTS_SUB_HI         3
`define DTS_SUB_LO         2
`define DTS_RISE_BIT       1
`define DTS_FALL_BIT       0

// Field positions of the synchronisation register.
`define DTS_LRUN_BIT       7
`define DTS_SRUN_BIT       6
`define DTS_SYNC_BIT       5

// Reset values, and the value that the reserved sync bits 4:0 read.
`define DTS_CTRL_RST       6'h00
`define DTS_START_RST      2'h0
`define DTS_FLAG_RST       2'h0
`define DTS_RUN_RST        2'h0
`define DTS_SYNC_RST       1'b0
`define DTS_RSVD_READ      5'h1F

// Glitch filter widths in system clock cycles; the filter counts to one less.
`define DTS_FILT_SHORT     5'h04
`define DTS_FILT_MID       5'h08
`define DTS_FILT_LONG      5'h10

`endif

// ---- src/dts_pkg.sv ----
package dts_pkg;

  typedef enum logic [1:0] {
    DTS_LOGIC_AND  = 2'h0,
    DTS_LOGIC_OR   = 2'h1,
    DTS_LOGIC_NOR  = 2'h2,
    DTS_LOGIC_NAND = 2'h3
  } dts_combine_t;

  typedef enum logic [1:0] {
    DTS_SUB_NORMAL = 2'h0,
    DTS_SUB_PING   = 2'h1,
    DTS_SUB_LOW    = 2'h2,
    DTS_SUB_HIGH   = 2'h3
  } dts_submode_t;

  typedef enum logic [1:0] {
    DTS_EDGE_FALL = 2'h0,
    DTS_EDGE_RISE = 2'h1,
    DTS_EDGE_BOTH = 2'h2,
    DTS_EDGE_RSVD = 2'h3
  } dts_edge_t;

  typedef enum logic [2:0] {
    DTS_REG_NONE = 3'h0,
    DTS_REG_CTRL = 3'h1,
    DTS_REG_SYNC = 3'h2,
    DTS_REG_STAT = 3'h3,
    DTS_REG_MASK = 3'h4
  } dts_reg_t;

endpackage : dts_pkg

// ---- src/dts_demod_filter.sv ----
`timescale 1ns/100ps
`include "dts_consts.svh"

module dts_demod_filter (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               demod_pin_a,
  input  wire logic               demod_pin_b,
  input  wire logic               sel_pin_a,
  input  wire dts_pkg::dts_edge_t edge_sel,
  input  wire logic [1:0]         filt_code,
  output logic                    rise_evt,
  output logic                    fall_evt
);
  import dts_pkg::*;

  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic       sel_s;
  logic       lvl_r;
  logic       lvl_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       rise_nxt;
  logic       fall_nxt;

  function automatic logic [3:0] filt_last(input logic [1:0] code);
    logic [4:0] len;
    case (code)
      2'h1:    len = `DTS_FILT_SHORT;
      2'h2:    len = `DTS_FILT_MID;
      2'h3:    len = `DTS_FILT_LONG;
      default: len = 5'h01;
    endcase
    filt_last = 4'(len - 5'h01);
  endfunction : filt_last

  // Both pins pass two flip-flops before the selector looks at them.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= (g == 0) ? demod_pin_a : demod_pin_b;
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign sel_s = sel_pin_a ? sync_r[0] : sync_r[1]; // RULE_07

  // A new level is accepted only after it has held for the whole filter width.
  always_comb begin
    lvl_nxt = lvl_r;
    cnt_nxt = 4'h0;
    if (sel_s != lvl_r) begin
      if (filt_code == 2'h0 || cnt_r >= filt_last(filt_code)) begin // RULE_09
        lvl_nxt = sel_s;
      end else begin
        cnt_nxt = 4'(cnt_r + 4'h1);
      end
    end
    rise_nxt = lvl_nxt & ~lvl_r & (edge_sel == DTS_EDGE_RISE || edge_sel == DTS_EDGE_BOTH); // RULE_08
    fall_nxt = ~lvl_nxt & lvl_r & (edge_sel == DTS_EDGE_FALL || edge_sel == DTS_EDGE_BOTH); // RULE_08
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_r    <= 1'b0;
      cnt_r    <= 4'h0;
      rise_evt <= 1'b0;
      fall_evt <= 1'b0;
    end else begin
      lvl_r    <= lvl_nxt;
      cnt_r    <= cnt_nxt;
      rise_evt <= rise_nxt;
      fall_evt <= fall_nxt;
    end
  end

  property p_edge_type;
    @(posedge pclk) disable iff (!presetn)
      rise_evt |-> $past(edge_sel) == DTS_EDGE_RISE || $past(edge_sel) == DTS_EDGE_BOTH;
  endproperty
  a_edge_type: assert property (p_edge_type) else $error("rise event with wrong edge select"); // RULE_08

  property p_filter_four;
    @(posedge pclk) disable iff (!presetn)
      (lvl_nxt != lvl_r) && filt_code == 2'h1 && $past(filt_code, 1) == 2'h1
        && $past(filt_code, 2) == 2'h1 && $past(filt_code, 3) == 2'h1
      |-> sel_s == $past(sel_s, 1) && sel_s == $past(sel_s, 2) && sel_s == $past(sel_s, 3);
  endproperty
  a_filter_four: assert property (p_filter_four) else $error("level passed 4-cycle filter early"); // RULE_09

endmodule : dts_demod_filter

// ---- src/dts_shared_ctrl.sv ----
// Notes on behaviour
// (RULE_01) Control bit 7: 1 demodulation, 0 transmit.
// (RULE_02) Transmit bit 6 routes combined output to pin.
// (RULE_03) Bits 5:4 combine: AND, OR, NOR, NAND.
// (RULE_04) Bits 3:2: normal, ping-pong, long forced 0/1.
// (RULE_05) Bit 1 sets short output start level.
// (RULE_06) Bit 0 sets long output start level.
// (RULE_07) Demod bit 6: 1 pin a, 0 pin b.
// (RULE_08) Bits 5:4 edge: falling, rising, both, reserved.
// (RULE_09) Bits 3:2 glitch filter: none, 4, 8, 16.
// (RULE_10) Bits 1:0 edge flags; write one clears.
// (RULE_11) Sync bits 7/6 start, stop, report counters.
// (RULE_12) Sync bit 5 enables sync; bits 4:0 read ones.
// (RULE_13) Flags set on filtered selected edges, stay set.
`timescale 1ns/100ps
`include "dts_consts.svh"

module dts_shared_ctrl (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic                      irq,
  input  wire logic                 demod_pin_a,
  input  wire logic                 demod_pin_b,
  input  wire logic                 short_counter_output,
  input  wire logic                 long_counter_output,
  input  wire logic                 short_counter_expired,
  input  wire logic                 long_counter_expired,
  output logic                      combined_output_pin_o,
  output logic                      combined_output_pin_oe,
  output logic                      demod_mode,
  output logic                      long_counter_run,
  output logic                      short_counter_run,
  output logic                      sync_mode_en,
  output dts_pkg::dts_submode_t     transmit_submode,
  output logic                      short_output_start_level,
  output logic                      long_output_start_level
);
  import dts_pkg::*;

  logic [7:2]  ctrl_r;
  logic [7:2]  ctrl_nxt;
  logic [1:0]  start_r;
  logic [1:0]  start_nxt;
  logic [1:0]  flag_r;
  logic [1:0]  flag_nxt;
  logic [1:0]  run_r;
  logic [1:0]  run_nxt;
  logic        sync_r;
  logic        sync_nxt;
  logic [1:0]  stat_r;
  logic [1:0]  stat_nxt;
  logic [1:0]  mask_r;
  logic [1:0]  mask_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        pin_o_r;
  logic        pin_o_nxt;
  logic        pin_oe_r;
  logic        pin_oe_nxt;
  logic        rise_evt;
  logic        fall_evt;
  logic [1:0]  edge_evt;
  logic        setup;
  logic        wr_acc;
  logic        rd_acc;
  dts_reg_t    reg_id;
  logic        long_eff;
  logic [31:0] rd_word;

  function automatic dts_reg_t reg_decode(input logic [7:0] addr);
    case (addr)
      `DTS_CTRL_ADDR: reg_decode = DTS_REG_CTRL;
      `DTS_SYNC_ADDR: reg_decode = DTS_REG_SYNC;
      `DTS_STAT_ADDR: reg_decode = DTS_REG_STAT;
      `DTS_MASK_ADDR: reg_decode = DTS_REG_MASK;
      default:        reg_decode = DTS_REG_NONE;
    endcase
  endfunction : reg_decode

  function automatic logic combine(input logic [1:0] code, input logic s, input logic l);
    case (dts_combine_t'(code))
      DTS_LOGIC_AND:  combine = s & l;
      DTS_LOGIC_OR:   combine = s | l;
      DTS_LOGIC_NOR:  combine = ~(s | l);
      default:        combine = ~(s & l);
    endcase
  endfunction : combine

  dts_demod_filter u_filter (
    .pclk        (pclk),
    .presetn     (presetn),
    .demod_pin_a (demod_pin_a),
    .demod_pin_b (demod_pin_b),
    .sel_pin_a   (ctrl_r[`DTS_SEL_BIT]),
    .edge_sel    (dts_edge_t'(ctrl_r[`DTS_LOGIC_HI:`DTS_LOGIC_LO])),
    .filt_code   (ctrl_r[`DTS_SUB_HI:`DTS_SUB_LO]),
    .rise_evt    (rise_evt),
    .fall_evt    (fall_evt)
  );

  // Edges count only while demodulation is selected.
  assign edge_evt = {rise_evt, fall_evt} & {2{ctrl_r[`DTS_MODE_BIT]}}; // RULE_13
  assign setup    = psel & ~penable;
  assign wr_acc   = psel & penable & pready_r & pwrite;
  assign rd_acc   = psel & penable & pready_r & ~pwrite;
  assign reg_id   = reg_decode(paddr);

  always_comb begin
    case (reg_id)
      DTS_REG_CTRL: rd_word = {24'h0, ctrl_r, ctrl_r[`DTS_MODE_BIT] ? flag_r : start_r}; // RULE_01
      DTS_REG_SYNC: rd_word = {24'h0, run_r, sync_r, `DTS_RSVD_READ}; // RULE_12
      DTS_REG_STAT: rd_word = {30'h0, stat_r};
      DTS_REG_MASK: rd_word = {30'h0, mask_r};
      default:      rd_word = 32'h0;
    endcase
  end

  // Register writes take effect at the access edge only.
  always_comb begin
    ctrl_nxt  = ctrl_r;
    start_nxt = start_r;
    flag_nxt  = flag_r;
    run_nxt   = run_r & ~{long_counter_expired, short_counter_expired};
    sync_nxt  = sync_r;
    mask_nxt  = mask_r;
    stat_nxt  = stat_r;
    if (wr_acc && reg_id == DTS_REG_CTRL) begin
      ctrl_nxt = pwdata[7:2]; // RULE_01
      if (!ctrl_r[`DTS_MODE_BIT]) begin
        start_nxt = pwdata[1:0]; // RULE_05 RULE_06
      end else begin
        flag_nxt = flag_r & ~pwdata[1:0]; // RULE_10
      end
    end
    if (wr_acc && reg_id == DTS_REG_SYNC) begin
      run_nxt  = pwdata[`DTS_LRUN_BIT:`DTS_SRUN_BIT]; // RULE_11
      sync_nxt = pwdata[`DTS_SYNC_BIT]; // RULE_12
    end
    if (wr_acc && reg_id == DTS_REG_MASK) begin
      mask_nxt = pwdata[1:0];
    end
    // Only the bits that the read actually returned are cleared, so an event
    // arriving between setup and access is not lost.
    if (rd_acc && reg_id == DTS_REG_STAT) begin
      stat_nxt = stat_r & ~prdata_r[1:0];
    end
    flag_nxt = flag_nxt | edge_evt; // RULE_10 RULE_13
    stat_nxt = stat_nxt | edge_evt;
    irq_nxt  = |(stat_r & mask_r);
  end

  // Combined pin path.
  always_comb begin
    case (dts_submode_t'(ctrl_r[`DTS_SUB_HI:`DTS_SUB_LO]))
      DTS_SUB_LOW:  long_eff = 1'b0; // RULE_04
      DTS_SUB_HIGH: long_eff = 1'b1; // RULE_04
      default:      long_eff = long_counter_output;
    endcase
    pin_o_nxt  = combine(ctrl_r[`DTS_LOGIC_HI:`DTS_LOGIC_LO], short_counter_output, long_eff); // RULE_03
    pin_oe_nxt = ~ctrl_r[`DTS_MODE_BIT] & ctrl_r[`DTS_ROUTE_BIT]; // RULE_02
  end

  // Zero-wait APB: ready is raised in every access phase one cycle after setup.
  always_comb begin
    pready_nxt  = setup;
    pslverr_nxt = setup & (reg_id == DTS_REG_NONE);
    prdata_nxt  = (setup && !pwrite) ? rd_word : prdata_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= `DTS_CTRL_RST;
      start_r   <= `DTS_START_RST;
      flag_r    <= `DTS_FLAG_RST;
      run_r     <= `DTS_RUN_RST;
      sync_r    <= `DTS_SYNC_RST;
      stat_r    <= 2'h0;
      mask_r    <= 2'h0;
      irq_r     <= 1'b0;
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      pin_o_r   <= 1'b0;
      pin_oe_r  <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      start_r   <= start_nxt;
      flag_r    <= flag_nxt;
      run_r     <= run_nxt;
      sync_r    <= sync_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      irq_r     <= irq_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      pin_o_r   <= pin_o_nxt;
      pin_oe_r  <= pin_oe_nxt;
    end
  end

  assign prdata                   = prdata_r;
  assign pready                   = pready_r;
  assign pslverr                  = pslverr_r;
  assign irq                      = irq_r;
  assign combined_output_pin_o    = pin_o_r;
  assign combined_output_pin_oe   = pin_oe_r;
  assign demod_mode               = ctrl_r[`DTS_MODE_BIT];
  assign long_counter_run         = run_r[1];
  assign short_counter_run        = run_r[0];
  assign sync_mode_en             = sync_r;
  assign transmit_submode         = dts_submode_t'(ctrl_r[`DTS_SUB_HI:`DTS_SUB_LO]);
  assign short_output_start_level = start_r[1];
  assign long_output_start_level  = start_r[0];

  property p_mode_write;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && reg_id == DTS_REG_CTRL |=> demod_mode == $past(pwdata[7]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode bit not taken from write"); // RULE_01

  property p_pin_drive;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> combined_output_pin_oe == $past(~ctrl_r[7] & ctrl_r[6]);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin enable does not follow route"); // RULE_02

  property p_and_combine;
    @(posedge pclk) disable iff (!presetn)
      ctrl_r[5:4] == 2'h0 && ctrl_r[3:2] == 2'h0
      |=> combined_output_pin_o == ($past(short_counter_output) & $past(long_counter_output));
  endproperty
  a_and_combine: assert property (p_and_combine) else $error("AND combine wrong"); // RULE_03

  property p_force_high;
    @(posedge pclk) disable iff (!presetn)
      ctrl_r[5:4] == 2'h1 && ctrl_r[3:2] == 2'h3 |=> combined_output_pin_o;
  endproperty
  a_force_high: assert property (p_force_high) else $error("forced-high long output lost"); // RULE_04

  property p_start_level;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && reg_id == DTS_REG_CTRL && !ctrl_r[7]
      |=> short_output_start_level == $past(pwdata[1]) && long_output_start_level == $past(pwdata[0]);
  endproperty
  a_start_level: assert property (p_start_level) else $error("start levels not stored"); // RULE_05 RULE_06

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && reg_id == DTS_REG_CTRL && ctrl_r[7] && pwdata[1] && !rise_evt |=> !flag_r[1];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("rise flag not cleared by write"); // RULE_10

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
      flag_r[0] && !(wr_acc && reg_id == DTS_REG_CTRL && ctrl_r[7] && pwdata[0]) |=> flag_r[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("fall flag dropped by itself"); // RULE_13

  property p_run_start;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && reg_id == DTS_REG_SYNC && pwdata[7] |=> long_counter_run ##1 1'b1;
  endproperty
  a_run_start: assert property (p_run_start) else $error("long counter did not start"); // RULE_11

  property p_sync_read;
    @(posedge pclk) disable iff (!presetn)
      rd_acc && reg_id == DTS_REG_SYNC
      |-> prdata[4:0] == 5'h1F && prdata[7:5] == $past({run_r, sync_r});
  endproperty
  a_sync_read: assert property (p_sync_read) else $error("sync register read wrong"); // RULE_12

  // An unmapped access is answered in the normal slot, flagged, and reads as zero.
  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
      setup && reg_id == DTS_REG_NONE |=> pready && pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      |(stat_r & mask_r) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  c_pin_routed: cover property (@(posedge pclk) disable iff (!presetn) combined_output_pin_oe);
  c_rise_flag:  cover property (@(posedge pclk) disable iff (!presetn) $rose(flag_r[1]));
  c_both_run:   cover property (@(posedge pclk) disable iff (!presetn) &run_r && sync_r);
  c_irq:        cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule : dts_shared_ctrl

// ---- testbench/dts_pin_model.sv ----
`timescale 1ns/100ps

// Stand-in for the two counters and the demodulator pins around the shared control block.
module dts_pin_model #(
  parameter logic [3:0] SHORT_LAST = 4'hB,
  parameter logic [3:0] LONG_LAST  = 4'hF
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic short_counter_run,
  input  wire logic long_counter_run,
  input  wire logic short_output_start_level,
  input  wire logic long_output_start_level,
  input  wire logic idle_short,
  input  wire logic idle_long,
  input  wire logic pin_a_lvl,
  input  wire logic pin_b_lvl,
  output logic      short_counter_output,
  output logic      long_counter_output,
  output logic      short_counter_expired,
  output logic      long_counter_expired,
  output logic      demod_pin_a,
  output logic      demod_pin_b
);
  logic [3:0] s_cnt_r;
  logic [3:0] l_cnt_r;
  logic       s_was_r;
  logic       l_was_r;

  // Each counter runs one pass and then reports expiry once, so the run bits must fall by
  // themselves.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {demod_pin_a, demod_pin_b, s_was_r, l_was_r} <= 4'h0;
      {short_counter_output, long_counter_output} <= 2'h0;
      {short_counter_expired, long_counter_expired} <= 2'h0;
      {s_cnt_r, l_cnt_r} <= 8'h00;
    end else begin
      demod_pin_a <= pin_a_lvl;
      demod_pin_b <= pin_b_lvl;
      s_was_r <= short_counter_run;
      l_was_r <= long_counter_run;
      s_cnt_r <= (short_counter_run && s_was_r) ? s_cnt_r + 4'h1 : 4'h0;
      l_cnt_r <= (long_counter_run && l_was_r) ? l_cnt_r + 4'h1 : 4'h0;
      short_counter_expired <= short_counter_run && s_was_r && (s_cnt_r == SHORT_LAST);
      long_counter_expired <= long_counter_run && l_was_r && (l_cnt_r == LONG_LAST);
      if (!short_counter_run) short_counter_output <= idle_short;
      else if (!s_was_r) short_counter_output <= short_output_start_level;
      else if (s_cnt_r[1:0] == 2'h3) short_counter_output <= !short_counter_output;
      if (!long_counter_run) long_counter_output <= idle_long;
      else if (!l_was_r) long_counter_output <= long_output_start_level;
      else if (l_cnt_r[1:0] == 2'h3) long_counter_output <= !long_counter_output;
    end
  end
endmodule : dts_pin_model

// ---- testbench/test_dual_timer_shared_control.sv ----
`timescale 1ns/100ps
`include "dts_consts.svh"

module test_dual_timer_shared_control;
  import dts_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata;
  logic         demod_pin_a, demod_pin_b, short_counter_output, long_counter_output;
  logic         short_counter_expired, long_counter_expired, demod_mode;
  logic         combined_output_pin_o, combined_output_pin_oe, sync_mode_en;
  logic         long_counter_run, short_counter_run;
  dts_submode_t transmit_submode;
  logic         short_output_start_level, long_output_start_level;
  logic         pin_a_lvl, pin_b_lvl, idle_short, idle_long, s, l, le, y;
  logic [1:0]   st, rf, stat_exp;
  logic [5:0]   ctl;
  logic [33:0]  exp_q[$];
  logic [33:0]  note;
  int           fail_count, num_checks, seed;

  dts_shared_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .demod_pin_a, .demod_pin_b, .short_counter_output,
    .long_counter_output, .short_counter_expired, .long_counter_expired,
    .combined_output_pin_o, .combined_output_pin_oe, .demod_mode, .long_counter_run,
    .short_counter_run, .sync_mode_en, .transmit_submode, .short_output_start_level,
    .long_output_start_level);

  dts_pin_model partner (.pclk, .presetn, .short_counter_run, .long_counter_run,
    .short_output_start_level, .long_output_start_level, .idle_short, .idle_long, .pin_a_lvl,
    .pin_b_lvl, .short_counter_output, .long_counter_output, .short_counter_expired,
    .long_counter_expired, .demod_pin_a, .demod_pin_b);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask : chk1

  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask : ticks

  // The upper write bits are random so that a design using them shows up as a mismatch.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] x, input logic err);
    exp_q.push_back({w, err, 24'h0, x});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'($random(seed)), d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // The request stands until the slave answers; only the watchdog ends a hang.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 8'h00, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00, x, 1'b0);
  endtask : rd

  task automatic drive(input logic sel, input logic v);
    if (sel) pin_a_lvl <= v;
    else pin_b_lvl <= v;
  endtask : drive

  task automatic pulse(input logic sel, input int w);
    drive(sel, 1'b1);
    ticks(w);
    drive(sel, 1'b0);
    ticks(30);
  endtask : pulse

  task automatic wrap_up;
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : {2'b01, 32'hFFFFFFFF};
      if (!note[33]) check(prdata, note[31:0]);
      chk1(pslverr, note[32]);
    end
  end

  initial begin
    ticks(20000);
    fail_count++;
    wrap_up;
  end

  initial begin
    seed = 32'h4E48CDF1;
    {psel, penable, pwrite, pin_a_lvl, pin_b_lvl, idle_short, idle_long} = 7'h00;
    {fail_count, num_checks, stat_exp, paddr, pwdata} = '0;
    presetn = 1'b0;
    ticks(20);
    presetn <= 1'b1;
    @(posedge pclk);
    chk1(combined_output_pin_oe, 1'b0);
    rd(`DTS_CTRL_ADDR, 8'h00);
    rd(`DTS_SYNC_ADDR, 8'h1F);
    rd(`DTS_STAT_ADDR, 8'h00);
    rd(`DTS_MASK_ADDR, 8'h00);
    apb(1'b0, 8'h08, 8'h00, 8'h00, 1'b1);
    apb(1'b1, 8'h00, 8'hFF, 8'h00, 1'b1);
    wr(`DTS_SYNC_ADDR, 8'h3F);
    chk1(sync_mode_en, 1'b1);
    rd(`DTS_SYNC_ADDR, 8'h3F);
    wr(`DTS_SYNC_ADDR, 8'hC0);
    chk1(long_counter_run & short_counter_run, 1'b1);
    rd(`DTS_SYNC_ADDR, 8'hDF);
    wr(`DTS_SYNC_ADDR, 8'h00);
    rd(`DTS_SYNC_ADDR, 8'h1F);
    wr(`DTS_SYNC_ADDR, 8'h80);
    ticks(40);
    rd(`DTS_SYNC_ADDR, 8'h1F);
    for (int c = 0; c < 4; c++) begin
      for (int m = 0; m < 4; m++) begin
        st = 2'($random(seed));
        s = 1'($random(seed));
        l = 1'($random(seed));
        idle_short <= s;
        idle_long <= l;
        wr(`DTS_CTRL_ADDR, {2'b01, c[1:0], m[1:0], st});
        ticks(2);
        le = (m == 2) ? 1'b0 : (m == 3) ? 1'b1 : l;
        case (c)
          0: y = s & le;
          1: y = s | le;
          2: y = ~(s | le);
          default: y = ~(s & le);
        endcase
        chk1(combined_output_pin_o, y);
        chk1(combined_output_pin_oe & ~demod_mode, 1'b1);
        check({30'h0, transmit_submode}, {30'h0, m[1:0]});
        check({30'h0, short_output_start_level, long_output_start_level}, {30'h0, st});
        rd(`DTS_CTRL_ADDR, {2'b01, c[1:0], m[1:0], st});
      end
    end
    wr(`DTS_CTRL_ADDR, 8'h30);
    ticks(2);
    chk1(combined_output_pin_oe, 1'b0);
    for (int i = 0; i < 2; i++) begin
      for (int e = 0; e < 4; e++) begin
        for (int f = 0; f < 4; f++) begin
          ctl = {1'b1, i[0], e[1:0], f[1:0]};
          rf = {e == 1 || e == 2, e == 0 || e == 2};
          wr(`DTS_CTRL_ADDR, {ctl, 2'b11});
          chk1(demod_mode & ~combined_output_pin_oe, 1'b1);
          pulse(!i[0], 30);
          if (f != 0) pulse(i[0], 2 << (f - 1));
          rd(`DTS_CTRL_ADDR, {ctl, 2'b00});
          drive(i[0], 1'b1);
          ticks(30);
          rd(`DTS_CTRL_ADDR, {ctl, rf[1], 1'b0});
          drive(i[0], 1'b0);
          ticks(30);
          rd(`DTS_CTRL_ADDR, {ctl, rf});
          wr(`DTS_CTRL_ADDR, {ctl, 2'b01});
          rd(`DTS_CTRL_ADDR, {ctl, rf[1], 1'b0});
          stat_exp = stat_exp | rf;
        end
      end
    end
    chk1(irq, 1'b0);
    rd(`DTS_STAT_ADDR, {6'h00, stat_exp});
    rd(`DTS_STAT_ADDR, 8'h00);
    wr(`DTS_MASK_ADDR, 8'h03);
    wr(`DTS_CTRL_ADDR, 8'hE3);
    drive(1'b1, 1'b1);
    ticks(10);
    chk1(irq, 1'b1);
    rd(`DTS_STAT_ADDR, 8'h02);
    ticks(2);
    chk1(irq, 1'b0);
    drive(1'b1, 1'b0);
    ticks(10);
    chk1(irq, 1'b1);
    rd(`DTS_STAT_ADDR, 8'h01);
    wrap_up;
  end
endmodule : test_dual_timer_shared_control
